// [rtl/nsp_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module nsp_controller (
	input  wire logic        clock,
	input  wire logic        resetn,
	nsp_if.controller        bus,
	input  wire logic [2:0]  sw_addr,
	input  wire logic [15:0] sw_wdata,
	input  wire logic        sw_write,
	input  wire logic        sw_read,
	output logic [15:0]      sw_rdata,
	output logic             irq
);
	import nsp_pkg::*;

	nsp_host_state_type state_reg;
	logic [7:0]  tgt_reg;
	logic [7:0]  val_reg;
	logic        rd_pend_reg;
	logic [7:0]  rdat_reg;
	logic [3:0]  stat_reg;
	logic [3:0]  mask_reg;
	logic [3:0]  events;
	logic        rest_target;
	logic [7:0]  fixed_val;
	logic        rd_status_reg;
	logic        wide_report_reg;

	// Above 500 dpi the host should switch to twelve-bit motion reports.
	function automatic logic wide_report(input logic [2:0] res);
		wide_report = (res != 3'h1) && (res != 3'h2);
	endfunction

	localparam logic WIDE_RESET = wide_report(RST_SENSOR_CONTROL[CTL_RES_LSB +: 3]);

	// Control writes keep the fixed bits; small run downshift values are raised to the minimum.
	always_comb begin
		fixed_val = sw_wdata[7:0];
		if (sw_wdata[14:8] == ADDR_SENSOR_CONTROL) begin
			fixed_val = (sw_wdata[7:0] & ~CONTROL_FIXED_MASK) | CONTROL_FIXED_VALUE;
		end else if (sw_wdata[14:8] == ADDR_RUN_IDLE_DOWNSHIFT && sw_wdata[7:0] < RUN_DOWNSHIFT_MIN) begin
			fixed_val = RUN_DOWNSHIFT_MIN;
		end
	end

	assign rest_target = (tgt_reg == {1'b0, ADDR_REST_ONE_PERIOD}) || (tgt_reg == {1'b0, ADDR_REST_TWO_PERIOD})
		|| (tgt_reg == {1'b0, ADDR_REST_THREE_PERIOD});

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= NSP_H_IDLE;
			tgt_reg   <= 8'h00;
			val_reg   <= 8'h00;
		end else begin
			case (state_reg)
				NSP_H_IDLE: begin
					if (sw_write && sw_addr == CMD_ADDR_DATA && !sw_wdata[15]) begin
						tgt_reg   <= {1'b0, sw_wdata[14:8]};
						val_reg   <= fixed_val;
						state_reg <= NSP_H_OPEN;
					end
				end
				NSP_H_OPEN: begin
					state_reg <= NSP_H_DATA;
				end
				NSP_H_DATA: begin
					state_reg <= rest_target ? NSP_H_CLOSE : NSP_H_IDLE;
				end
				NSP_H_CLOSE: begin
					state_reg <= NSP_H_IDLE;
				end
				default: begin
					state_reg <= NSP_H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wide_report_reg <= WIDE_RESET;
		end else if (state_reg == NSP_H_IDLE && sw_write && sw_addr == CMD_ADDR_DATA && !sw_wdata[15]
			&& sw_wdata[14:8] == ADDR_SENSOR_CONTROL) begin
			wide_report_reg <= wide_report(sw_wdata[CTL_RES_LSB +: 3]);
		end
	end

	// Rest period writes are wrapped by guard open and close writes.
	always_comb begin
		bus.wr    = 1'b0;
		bus.rd    = 1'b0;
		bus.addr  = 7'h00;
		bus.wdata = 8'h00;
		if (state_reg == NSP_H_OPEN && rest_target) begin
			bus.wr    = 1'b1;
			bus.addr  = ADDR_REST_GUARD;
			bus.wdata = GUARD_OPEN;
		end else if (state_reg == NSP_H_DATA) begin
			bus.wr    = 1'b1;
			bus.addr  = tgt_reg[6:0];
			bus.wdata = val_reg;
		end else if (state_reg == NSP_H_CLOSE) begin
			bus.wr    = 1'b1;
			bus.addr  = ADDR_REST_GUARD;
			bus.wdata = GUARD_CLOSE;
		end else if (state_reg == NSP_H_IDLE && sw_write && sw_addr == CMD_ADDR_DATA && sw_wdata[15]) begin
			bus.rd   = 1'b1;
			bus.addr = sw_wdata[14:8];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_pend_reg   <= 1'b0;
			rd_status_reg <= 1'b0;
			rdat_reg      <= 8'h00;
		end else begin
			rd_pend_reg   <= bus.rd;
			rd_status_reg <= bus.rd && bus.addr == ADDR_MOTION_STATUS_EXT;
			if (rd_pend_reg) begin
				rdat_reg <= bus.rdata;
			end
		end
	end

	assign events[0] = rd_status_reg && bus.rdata[MSX_MOTION_BIT];
	assign events[1] = state_reg == NSP_H_DATA;
	assign events[2] = state_reg == NSP_H_CLOSE;
	assign events[3] = rd_status_reg && (bus.rdata[MSX_Y_OVERFLOW_BIT] | bus.rdata[MSX_X_OVERFLOW_BIT]);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stat_reg <= 4'h0;
			mask_reg <= 4'h0;
		end else begin
			if (sw_read && sw_addr == CMD_ADDR_STAT) begin
				stat_reg <= events;
			end else begin
				stat_reg <= stat_reg | events;
			end
			if (sw_write && sw_addr == CMD_ADDR_MASK) begin
				mask_reg <= sw_wdata[3:0];
			end
		end
	end

	assign irq = |(stat_reg & mask_reg);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sw_rdata <= 16'h0000;
		end else if (sw_read) begin
			case (sw_addr)
				CMD_ADDR_CTRL: sw_rdata <= {wide_report_reg, 13'h0000, state_reg};
				CMD_ADDR_STAT: sw_rdata <= {12'h000, stat_reg};
				CMD_ADDR_MASK: sw_rdata <= {12'h000, mask_reg};
				CMD_ADDR_RDAT: sw_rdata <= {8'h00, rdat_reg};
				default:       sw_rdata <= 16'h0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// [rtl/nsp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface nsp_if;
	logic       wr;
	logic       rd;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport sensor (input wr, input rd, input addr, input wdata, output rdata);
	modport controller (output wr, output rd, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

// [rtl/nsp_pkg.sv]
package nsp_pkg;

	localparam logic [6:0] ADDR_SENSOR_CONTROL       = 7'h0D;
	localparam logic [6:0] ADDR_RUN_IDLE_DOWNSHIFT   = 7'h0E;
	localparam logic [6:0] ADDR_REST_ONE_PERIOD      = 7'h0F;
	localparam logic [6:0] ADDR_REST_ONE_DOWNSHIFT   = 7'h10;
	localparam logic [6:0] ADDR_REST_TWO_PERIOD      = 7'h11;
	localparam logic [6:0] ADDR_REST_TWO_DOWNSHIFT   = 7'h12;
	localparam logic [6:0] ADDR_REST_THREE_PERIOD    = 7'h13;
	localparam logic [6:0] ADDR_LED_PRELIGHT_NORMAL  = 7'h14;
	localparam logic [6:0] ADDR_LED_PRELIGHT_DARK    = 7'h18;
	localparam logic [6:0] ADDR_MOTION_STATUS_EXT    = 7'h1B;
	localparam logic [6:0] ADDR_REST_GUARD           = 7'h22;

	localparam logic [7:0] RST_SENSOR_CONTROL        = 8'h20;
	localparam logic [7:0] RST_RUN_IDLE_DOWNSHIFT    = 8'h46;
	localparam logic [7:0] RST_REST_ONE_PERIOD       = 8'h00;
	localparam logic [7:0] RST_REST_ONE_DOWNSHIFT    = 8'h4F;
	localparam logic [7:0] RST_REST_TWO_PERIOD       = 8'h09;
	localparam logic [7:0] RST_REST_TWO_DOWNSHIFT    = 8'h2F;
	localparam logic [7:0] RST_REST_THREE_PERIOD     = 8'h31;
	localparam logic [7:0] RST_LED_PRELIGHT          = 8'h80;

	localparam logic [7:0] RUN_DOWNSHIFT_MIN         = 8'h46;
	localparam logic [7:0] REST_PERIOD_MAX           = 8'hFD;
	localparam logic [7:0] GUARD_OPEN                = 8'h80;
	localparam logic [7:0] GUARD_CLOSE               = 8'h00;
	localparam logic [7:0] CONTROL_FIXED_MASK        = 8'h21;
	localparam logic [7:0] CONTROL_FIXED_VALUE       = 8'h20;

	localparam int CTL_POWER_DOWN_BIT   = 1;
	localparam int CTL_RES_LSB          = 2;
	localparam int PRELIGHT_SELECT_BIT  = 7;
	localparam int MSX_MOTION_BIT       = 7;
	localparam int MSX_GRAB_VALID_BIT   = 6;
	localparam int MSX_GRAB_FIRST_BIT   = 5;
	localparam int MSX_Y_OVERFLOW_BIT   = 4;
	localparam int MSX_X_OVERFLOW_BIT   = 3;

	localparam int RUN_FRAME_UNIT       = 16;
	localparam int REST_ONE_FACTOR      = 16;
	localparam int REST_TWO_FACTOR      = 128;
	localparam int PRELIGHT_IDLE_UNIT   = 64;
	localparam int PRELIGHT_PROC_UNIT   = 32;
	localparam int PRELIGHT_DARK_LIMIT  = 110;

	localparam int CLOCK_MHZ            = 125;
	localparam int REST_TICK_US         = 7000;
	localparam int REST_TICK_CYCLES     = REST_TICK_US * CLOCK_MHZ;

	localparam logic [3:0] STAT_MOTION   = 4'h1;
	localparam logic [3:0] STAT_SHIFT    = 4'h2;
	localparam logic [3:0] STAT_WAKE     = 4'h4;
	localparam logic [3:0] STAT_OVERFLOW = 4'h8;
	localparam logic [2:0] CMD_ADDR_CTRL = 3'h0;
	localparam logic [2:0] CMD_ADDR_DATA = 3'h1;
	localparam logic [2:0] CMD_ADDR_STAT = 3'h2;
	localparam logic [2:0] CMD_ADDR_MASK = 3'h3;
	localparam logic [2:0] CMD_ADDR_RDAT = 3'h4;

	typedef enum logic [1:0] {
		NSP_RUN          = 2'b00,
		NSP_FIRST_IDLE   = 2'b01,
		NSP_SECOND_IDLE  = 2'b10,
		NSP_THIRD_IDLE   = 2'b11
	} nsp_mode_type;

	typedef enum logic [1:0] {
		NSP_H_IDLE   = 2'b00,
		NSP_H_OPEN   = 2'b01,
		NSP_H_DATA   = 2'b10,
		NSP_H_CLOSE  = 2'b11
	} nsp_host_state_type;

endpackage

// [rtl/nsp_sensor.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Three-bit field picks resolution, default 1000.
// - Power-down bit one stops the sensor; here mode is held at run and frame_start still follows frame_tick.
// - Controller uses 12-bit reports above 500.
// - Run downshift counted in sixteen-frame units.
// - Controller writes run downshift 0x46 or more.
// - First idle period is value+1 times 7ms.
// - First downshift is value times period times 16.
// - Second idle period is value+1 times 7ms.
// - Second downshift is value times period times 128.
// - Third idle period is value+1 times 7ms.
// - Controller guards rest writes with 0x80/0x00.
// - Bit 7 picks idle or processing prelight.
// - Idle prelight is field times 64 clocks.
// - Processing prelight is proc minus field*32 plus idle.
// - Dark prelight over 110 counts is idle only.
// - Status bit 7 shows motion occurred.
// - Status bits 6 and 5 show grab valid, first.
// - Bits 4, 3 flag Y, X overflow.
module nsp_sensor #(
	parameter int TICK_CYCLES  = nsp_pkg::REST_TICK_CYCLES,
	parameter int PROC_CYCLES  = 3520,
	parameter int IDLE_CYCLES  = 512
) (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	nsp_if.sensor                      bus,
	input  wire logic                  frame_tick,
	input  wire logic                  motion_seen,
	input  wire logic                  grab_valid,
	input  wire logic                  grab_first,
	input  wire logic                  y_overflow,
	input  wire logic                  x_overflow,
	input  wire logic                  dark_surface,
	output logic [2:0]                 resolution_code,
	output logic                       powered_down,
	output nsp_pkg::nsp_mode_type      mode,
	output logic                       frame_start,
	output logic [15:0]                prelight_cycles,
	output logic                       prelight_in_processing
);
	import nsp_pkg::*;

	logic [7:0]  control_reg;
	logic [7:0]  run_ds_reg;
	logic [7:0]  r1_per_reg;
	logic [7:0]  r1_ds_reg;
	logic [7:0]  r2_per_reg;
	logic [7:0]  r2_ds_reg;
	logic [7:0]  r3_per_reg;
	logic [7:0]  pl_norm_reg;
	logic [7:0]  pl_dark_reg;
	logic [7:0]  guard_reg;
	logic [4:0]  msx_reg;
	logic [31:0] tick_cnt_reg;
	logic [7:0]  period_cnt_reg;
	logic [19:0] frame_cnt_reg;
	logic        rest_tick;
	logic        rest_frame;
	logic [7:0]  cur_period;
	logic [19:0] limit;
	logic [7:0]  pl;

	function automatic logic [7:0] clamp_period(input logic [7:0] v);
		clamp_period = (v > REST_PERIOD_MAX) ? REST_PERIOD_MAX : v;
	endfunction

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			control_reg <= RST_SENSOR_CONTROL;
			run_ds_reg  <= RST_RUN_IDLE_DOWNSHIFT;
			r1_per_reg  <= RST_REST_ONE_PERIOD;
			r1_ds_reg   <= RST_REST_ONE_DOWNSHIFT;
			r2_per_reg  <= RST_REST_TWO_PERIOD;
			r2_ds_reg   <= RST_REST_TWO_DOWNSHIFT;
			r3_per_reg  <= RST_REST_THREE_PERIOD;
			pl_norm_reg <= RST_LED_PRELIGHT;
			pl_dark_reg <= RST_LED_PRELIGHT;
			guard_reg   <= GUARD_CLOSE;
		end else if (bus.wr) begin
			case (bus.addr)
				ADDR_SENSOR_CONTROL: begin
					control_reg <= (bus.wdata & ~CONTROL_FIXED_MASK) | CONTROL_FIXED_VALUE;
				end
				ADDR_RUN_IDLE_DOWNSHIFT: begin
					run_ds_reg <= bus.wdata;
				end
				ADDR_REST_ONE_PERIOD: begin
					r1_per_reg <= clamp_period(bus.wdata);
				end
				ADDR_REST_ONE_DOWNSHIFT: begin
					r1_ds_reg <= bus.wdata;
				end
				ADDR_REST_TWO_PERIOD: begin
					r2_per_reg <= clamp_period(bus.wdata);
				end
				ADDR_REST_TWO_DOWNSHIFT: begin
					r2_ds_reg <= bus.wdata;
				end
				ADDR_REST_THREE_PERIOD: begin
					r3_per_reg <= clamp_period(bus.wdata);
				end
				ADDR_LED_PRELIGHT_NORMAL: begin
					pl_norm_reg <= bus.wdata;
				end
				ADDR_LED_PRELIGHT_DARK: begin
					pl_dark_reg <= bus.wdata;
				end
				ADDR_REST_GUARD: begin
					guard_reg <= bus.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus.rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				ADDR_SENSOR_CONTROL:      bus.rdata <= control_reg;
				ADDR_RUN_IDLE_DOWNSHIFT:  bus.rdata <= run_ds_reg;
				ADDR_REST_ONE_PERIOD:     bus.rdata <= r1_per_reg;
				ADDR_REST_ONE_DOWNSHIFT:  bus.rdata <= r1_ds_reg;
				ADDR_REST_TWO_PERIOD:     bus.rdata <= r2_per_reg;
				ADDR_REST_TWO_DOWNSHIFT:  bus.rdata <= r2_ds_reg;
				ADDR_REST_THREE_PERIOD:   bus.rdata <= r3_per_reg;
				ADDR_LED_PRELIGHT_NORMAL: bus.rdata <= pl_norm_reg;
				ADDR_LED_PRELIGHT_DARK:   bus.rdata <= pl_dark_reg;
				ADDR_MOTION_STATUS_EXT:   bus.rdata <= {msx_reg, 3'b000};
				ADDR_REST_GUARD:          bus.rdata <= guard_reg;
				default:                  bus.rdata <= 8'h00;
			endcase
		end
	end

	// Motion and overflow flags are sticky until the status register is read; grab flags follow live.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			msx_reg <= 5'h00;
		end else begin
			msx_reg[4] <= motion_seen | (msx_reg[4] & ~(bus.rd && bus.addr == ADDR_MOTION_STATUS_EXT));
			msx_reg[3] <= grab_valid;
			msx_reg[2] <= grab_first;
			msx_reg[1] <= y_overflow | (msx_reg[1] & ~(bus.rd && bus.addr == ADDR_MOTION_STATUS_EXT));
			msx_reg[0] <= x_overflow | (msx_reg[0] & ~(bus.rd && bus.addr == ADDR_MOTION_STATUS_EXT));
		end
	end

	assign resolution_code = control_reg[CTL_RES_LSB +: 3];
	assign powered_down    = control_reg[CTL_POWER_DOWN_BIT];

	always_comb begin
		case (mode)
			NSP_FIRST_IDLE:  cur_period = r1_per_reg;
			NSP_SECOND_IDLE: cur_period = r2_per_reg;
			NSP_THIRD_IDLE:  cur_period = r3_per_reg;
			default:         cur_period = 8'h00;
		endcase
	end

	// Rest frames come every (period+1) ticks of 7 ms; the guard open value freezes the period count.
	assign rest_tick  = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
	assign rest_frame = rest_tick && (period_cnt_reg >= cur_period) && (guard_reg != GUARD_OPEN);
	assign frame_start = (mode == NSP_RUN) ? frame_tick : rest_frame;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_reg   <= 32'h0;
			period_cnt_reg <= 8'h00;
		end else if (mode == NSP_RUN || powered_down) begin
			tick_cnt_reg   <= 32'h0;
			period_cnt_reg <= 8'h00;
		end else if (rest_tick) begin
			tick_cnt_reg   <= 32'h0;
			period_cnt_reg <= rest_frame ? 8'h00 : period_cnt_reg + ((guard_reg == GUARD_OPEN) ? 8'h00 : 8'h01);
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end

	always_comb begin
		case (mode)
			NSP_RUN:         limit = 20'(run_ds_reg * RUN_FRAME_UNIT);
			NSP_FIRST_IDLE:  limit = 20'(r1_ds_reg * REST_ONE_FACTOR);
			NSP_SECOND_IDLE: limit = 20'(r2_ds_reg * REST_TWO_FACTOR);
			default:         limit = 20'hFFFFF;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode          <= NSP_RUN;
			frame_cnt_reg <= 20'h0;
		end else if (powered_down) begin
			mode          <= NSP_RUN;
			frame_cnt_reg <= 20'h0;
		end else if (motion_seen) begin
			mode          <= NSP_RUN;
			frame_cnt_reg <= 20'h0;
		end else if (frame_start && mode != NSP_THIRD_IDLE) begin
			if (frame_cnt_reg + 20'h1 >= limit) begin
				case (mode)
					NSP_RUN:         mode <= NSP_FIRST_IDLE;
					NSP_FIRST_IDLE:  mode <= NSP_SECOND_IDLE;
					NSP_SECOND_IDLE: mode <= NSP_THIRD_IDLE;
					default:         mode <= NSP_THIRD_IDLE;
				endcase
				frame_cnt_reg <= 20'h0;
			end else begin
				frame_cnt_reg <= frame_cnt_reg + 20'h1;
			end
		end
	end

	assign pl = dark_surface ? pl_dark_reg : pl_norm_reg;
	assign prelight_in_processing = pl[PRELIGHT_SELECT_BIT];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prelight_cycles <= 16'h0;
		end else if (!pl[PRELIGHT_SELECT_BIT]) begin
			prelight_cycles <= 16'(pl[6:0] * PRELIGHT_IDLE_UNIT);
		end else if (dark_surface && pl[6:0] > 7'(PRELIGHT_DARK_LIMIT)) begin
			prelight_cycles <= 16'(IDLE_CYCLES);
		end else begin
			prelight_cycles <= 16'(PROC_CYCLES - pl[6:0] * PRELIGHT_PROC_UNIT + IDLE_CYCLES);
		end
	end

endmodule
`default_nettype wire

// [tb/nsp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module nsp_monitor (
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	import nsp_pkg::*;
	logic is_rest;
	assign is_rest = addr == ADDR_REST_ONE_PERIOD || addr == ADDR_REST_TWO_PERIOD || addr == ADDR_REST_THREE_PERIOD;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence open_s;
		wr && addr == ADDR_REST_GUARD && wdata == GUARD_OPEN;
	endsequence
	sequence target_s;
		wr && is_rest;
	endsequence
	sequence close_s;
		wr && addr == ADDR_REST_GUARD && wdata == GUARD_CLOSE;
	endsequence
	guard_open_a: assert property (open_s |=> target_s)
		else $error("No rest write after guard open.");
	guard_close_a: assert property (open_s ##1 target_s |=> close_s)
		else $error("No guard close after rest write.");
	guarded_write_a: assert property (wr && is_rest |-> $past(wr && addr == ADDR_REST_GUARD && wdata == GUARD_OPEN))
		else $error("Rest write without guard open.");
	run_floor_a: assert property (wr && addr == ADDR_RUN_IDLE_DOWNSHIFT |-> wdata >= RUN_DOWNSHIFT_MIN)
		else $error("Run downshift written below floor.");
	control_fixed_a: assert property (rd && addr == ADDR_SENSOR_CONTROL |=>
		(rdata & CONTROL_FIXED_MASK) == CONTROL_FIXED_VALUE) else $error("Control fixed bits wrong.");
	rest_clamp_a: assert property (rd && is_rest |=> rdata <= REST_PERIOD_MAX)
		else $error("Rest period above limit.");
	status_reserved_a: assert property (rd && addr == ADDR_MOTION_STATUS_EXT |=> rdata[2:0] == 3'h0)
		else $error("Status reserved bits set.");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("Read data changed without a read.");
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import nsp_pkg::*;
	logic         clock;
	logic         resetn;
	logic [2:0]   sw_addr;
	logic [15:0]  sw_wdata;
	logic         sw_write;
	logic         sw_read;
	logic [15:0]  sw_rdata;
	logic         irq;
	logic         frame_tick;
	logic         motion_seen;
	logic         grab_valid;
	logic         grab_first;
	logic         y_overflow;
	logic         x_overflow;
	logic         dark_surface;
	logic [2:0]   resolution_code;
	logic         powered_down;
	nsp_mode_type mode;
	logic         frame_start;
	logic [15:0]  prelight_cycles;
	logic         prelight_in_processing;
	logic         tick_en;
	logic [1:0]   fcnt;
	logic         rd_d;
	logic [15:0]  exp_q[$];
	logic [15:0]  msk_q[$];
	logic [7:0]   v;
	int           errors;
	int           total_checks;
	int           seed;
	int           i;
	int           n;
	int           f;
	logic [6:0]   ra [9] = '{7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h18};
	logic [7:0]   rv [9] = '{8'h20, 8'h46, 8'h00, 8'h4F, 8'h09, 8'h2F, 8'h31, 8'h80, 8'h80};
	nsp_if        link ();
	nsp_sensor #(.TICK_CYCLES(10)) i_nsp_sensor (.clock(clock), .resetn(resetn), .bus(link),
		.frame_tick(frame_tick), .motion_seen(motion_seen), .grab_valid(grab_valid), .grab_first(grab_first),
		.y_overflow(y_overflow), .x_overflow(x_overflow), .dark_surface(dark_surface),
		.resolution_code(resolution_code), .powered_down(powered_down), .mode(mode), .frame_start(frame_start),
		.prelight_cycles(prelight_cycles), .prelight_in_processing(prelight_in_processing));
	nsp_controller i_nsp_controller (.clock(clock), .resetn(resetn), .bus(link), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .irq(irq));
	nsp_monitor i_nsp_monitor (.clock(clock), .resetn(resetn), .wr(link.wr), .rd(link.rd), .addr(link.addr),
		.wdata(link.wdata), .rdata(link.rdata));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("Checks %0d, mismatches %0d.", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task expire(input logic hit);
		if (hit) begin
			errors++;
			stop_test;
		end
	endtask
	task sw_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_wdata <= d;
		sw_write <= 1'b1;
		@(posedge clock);
		sw_write <= 1'b0;
	endtask
	task sw_rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clock);
		sw_addr <= a;
		sw_read <= 1'b1;
		@(posedge clock);
		sw_read <= 1'b0;
	endtask
	task wait_idle;
		int k;
		for (k = 0; k < 20; k++) begin
			sw_rd(CMD_ADDR_CTRL, 16'h0000, 16'h0000);
			#1;
			if (sw_rdata[1:0] === 2'b00) break;
		end
		expire(k == 20);
	endtask
	task cmd_wr(input logic [6:0] a, input logic [7:0] d);
		sw_wr(CMD_ADDR_DATA, {1'b0, a, d});
		wait_idle;
	endtask
	task cmd_rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
		sw_wr(CMD_ADDR_DATA, {1'b1, a, 8'h00});
		wait_idle;
		sw_rd(CMD_ADDR_RDAT, {8'h00, e}, {8'h00, m});
	endtask
	always @(posedge clock) begin
		rd_d <= sw_read;
		fcnt <= fcnt + 2'd1;
		frame_tick <= tick_en && fcnt == 2'd3;
	end
	always @(negedge clock) begin
		if (rd_d && exp_q.size() > 0) begin
			if (msk_q[0] !== 16'h0000) check(sw_rdata & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		seed = 32'h253F;
		errors = 0;
		total_checks = 0;
		{resetn, sw_write, sw_read, motion_seen, grab_valid, grab_first} = 6'h00;
		{y_overflow, x_overflow, dark_surface, tick_en, rd_d, frame_tick} = 6'h00;
		sw_addr = 3'h0;
		sw_wdata = 16'h0000;
		fcnt = 2'h0;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		for (i = 0; i < 9; i++) cmd_rd(ra[i], rv[i], 8'hFF);
		cmd_rd(ADDR_MOTION_STATUS_EXT, 8'h00, 8'hFF);
		sw_rd(CMD_ADDR_CTRL, 16'h8000, 16'h8000);
		$display("Reset values done.");
		for (i = 0; i < 7; i++) begin
			v = 8'($random(seed));
			v[4:2] = i[2:0];
			v[1] = 1'b0;
			cmd_wr(ADDR_SENSOR_CONTROL, v);
			check(16'(resolution_code), 16'(i[2:0]));
			cmd_rd(ADDR_SENSOR_CONTROL, {3'b001, i[2:0], 2'b00}, 8'h3F);
			sw_rd(CMD_ADDR_CTRL, {(i != 1 && i != 2), 15'h0000}, 16'h8000);
		end
		cmd_wr(ADDR_SENSOR_CONTROL, 8'h22);
		check(16'(powered_down), 16'h0001);
		cmd_wr(ADDR_SENSOR_CONTROL, 8'h20);
		check(16'(powered_down), 16'h0000);
		$display("Control done.");
		cmd_wr(ADDR_RUN_IDLE_DOWNSHIFT, 8'h10);
		cmd_rd(ADDR_RUN_IDLE_DOWNSHIFT, RUN_DOWNSHIFT_MIN, 8'hFF);
		for (i = 0; i < 3; i++) begin
			cmd_wr(ADDR_REST_ONE_PERIOD + 7'(2 * i), 8'hFF);
			cmd_rd(ADDR_REST_ONE_PERIOD + 7'(2 * i), REST_PERIOD_MAX, 8'hFF);
			cmd_wr(ADDR_REST_ONE_PERIOD + 7'(2 * i), 8'h00);
		end
		$display("Limits done.");
		cmd_wr(ADDR_LED_PRELIGHT_NORMAL, 8'h05);
		check(prelight_cycles, 16'd320);
		check(16'(prelight_in_processing), 16'h0000);
		cmd_wr(ADDR_LED_PRELIGHT_NORMAL, 8'h85);
		check(prelight_cycles, 16'd3872);
		@(posedge clock);
		dark_surface <= 1'b1;
		cmd_wr(ADDR_LED_PRELIGHT_DARK, 8'hED);
		check(prelight_cycles, 16'd544);
		check(16'(prelight_in_processing), 16'h0001);
		cmd_wr(ADDR_LED_PRELIGHT_DARK, 8'hEF);
		check(prelight_cycles, 16'd512);
		$display("Prelight done.");
		v = 8'($random(seed));
		@(posedge clock);
		{grab_valid, grab_first, motion_seen, y_overflow, x_overflow} <= {v[6:5], 3'b111};
		@(posedge clock);
		{motion_seen, y_overflow, x_overflow} <= 3'b000;
		cmd_rd(ADDR_MOTION_STATUS_EXT, {1'b1, v[6:5], 5'h18}, 8'hFF);
		cmd_rd(ADDR_MOTION_STATUS_EXT, {1'b0, v[6:5], 5'h00}, 8'hFF);
		sw_wr(CMD_ADDR_MASK, 16'h000D);
		sw_rd(CMD_ADDR_STAT, 16'h000F, 16'h000F);
		cmd_wr(ADDR_LED_PRELIGHT_NORMAL, 8'h80);
		check(16'(irq), 16'h0000);
		sw_wr(CMD_ADDR_MASK, 16'h000F);
		#1;
		check(16'(irq), 16'h0001);
		sw_rd(CMD_ADDR_STAT, 16'h0002, 16'h0002);
		#1;
		check(16'(irq), 16'h0000);
		$display("Status done.");
		cmd_wr(ADDR_REST_ONE_DOWNSHIFT, 8'h01);
		cmd_wr(ADDR_REST_TWO_DOWNSHIFT, 8'h01);
		tick_en <= 1'b1;
		n = 0;
		for (f = 0; mode === NSP_RUN && f < 6000; f++) begin
			@(posedge clock);
			#1;
			if (frame_tick) n++;
		end
		tick_en <= 1'b0;
		expire(f == 6000);
		check(16'(n), 16'd1120);
		check(16'(mode), 16'(NSP_FIRST_IDLE));
		f = 0;
		for (n = 0; mode === NSP_FIRST_IDLE && n < 400; n++) begin
			@(posedge clock);
			#1;
			if (frame_start) f++;
		end
		expire(n == 400);
		check(16'(n > 150 && n < 175), 16'h0001);
		check(16'(f >= 15 && f <= 17), 16'h0001);
		check(16'(mode), 16'(NSP_SECOND_IDLE));
		for (n = 0; mode === NSP_SECOND_IDLE && n < 2000; n++) @(posedge clock);
		expire(n == 2000);
		check(16'(n > 1270 && n < 1295), 16'h0001);
		check(16'(mode), 16'(NSP_THIRD_IDLE));
		@(posedge clock);
		motion_seen <= 1'b1;
		@(posedge clock);
		motion_seen <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check(16'(mode), 16'(NSP_RUN));
		$display("Downshift done.");
		stop_test;
	end
endmodule
`default_nettype wire
